/* File: rtl/ipc_ctrl.sv */
// idle and power-down controller with an axi4-lite register slave
// assumes the core stalls while cpu_clk_en is low and takes its
// interrupt itself; wake pins and reset pin are asynchronous
//
// Operation
// - write setting idle bit gates cpu clock right after that write
// - idle stops cpu clock only; peripheral clock keeps running
// - idle keeps all cpu registers by gating, never resetting
// - ports hold their levels while idle
// - address latch and program store strobes forced high in idle
// - enabled interrupt in idle clears idle bit, idle ends
// - after idle wake core resumes at next instruction, no reset
// - two general flags, software writable and readable
// - reset pin low for 24 clocks completes reset
// - power-down stops oscillator after the requesting write
// - power-down keeps ram and registers, no reset applied
// - power-down ends on hardware reset or qualified interrupt
// - only the two wake pins, keyboard and usb can wake power-down
// - wake source counts only if enabled and level or edge
// - keyboard wake waits 1024 clocks before running
// - wake pin low restarts oscillator, release completes exit
// - with both pins, first release completes the exit
// - simultaneous pin wake reports higher priority source
// - after power-down wake core resumes at next instruction
`timescale 1ns/1ps
`include "ipc_params.svh"
module ipc_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq_pending,
    input wire logic kbd_irq,
    input wire logic usb_irq,
    input wire logic external_irq_zero_n,
    input wire logic external_irq_one_n,
    input wire logic hw_reset_n,
    input wire logic core_ale,
    input wire logic core_program_store_strobe,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_en,
    output logic port_hold,
    output logic ale,
    output logic program_store_strobe,
    output logic core_reset,
    output logic wake_valid,
    output logic [3:0] wake_src
);
    // ------------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------------
    ipc_pkg::ipc_state_t state;
    ipc_pkg::ipc_state_t next_state;
    ipc_pkg::ipc_pwr_ctrl_t power_control_register;
    ipc_pkg::ipc_pwr_ctrl_t next_pwr;
    ipc_pkg::ipc_wake_cfg_t wake_cfg;
    logic [3:0] wake_latch;
    logic [3:0] next_wake_latch;
    logic [3:0] src_lvl_q;
    logic next_wake_valid;
    logic [3:0] next_wake_src;

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_pwr;
    logic wr_cfg;
    logic wr_ok;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_pwr = wr_fire && (aw_addr == `IPC_OFS_PWR_CTRL) && w_strb[0];
    assign wr_cfg = wr_fire && (aw_addr == `IPC_OFS_WAKE_CFG) && w_strb[0];
    assign wr_ok = (aw_addr == `IPC_OFS_PWR_CTRL)
        || (aw_addr == `IPC_OFS_WAKE_CFG) || (aw_addr == `IPC_OFS_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    logic rd_ok;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_ok = (s_axi_araddr == `IPC_OFS_PWR_CTRL)
        || (s_axi_araddr == `IPC_OFS_WAKE_CFG)
        || (s_axi_araddr == `IPC_OFS_STATUS);
    assign rd_mux =
        (s_axi_araddr == `IPC_OFS_PWR_CTRL) ?
            {28'h0000000, power_control_register} :
        (s_axi_araddr == `IPC_OFS_WAKE_CFG) ? {24'h000000, wake_cfg} :
        (s_axi_araddr == `IPC_OFS_STATUS) ?
            {25'h0000000, wake_latch, state} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pins_s;

    ipc_sync #(.W(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({hw_reset_n, external_irq_one_n, external_irq_zero_n}),
        .sync_out(pins_s)
    );

    // ------------------------------------------------------------------
    // wake qualification
    // ------------------------------------------------------------------
    logic [3:0] src_lvl;
    logic [3:0] src_edge;
    logic [3:0] src_start;
    logic [3:0] src_pick;
    logic any_start;
    logic latched_release;
    logic rst_low;

    // only these four sources exist as wake inputs
    assign src_lvl = {usb_irq, kbd_irq, ~pins_s[1], ~pins_s[0]};
    assign src_edge = src_lvl & ~src_lvl_q;
    assign src_start = wake_cfg.enable
        & ((wake_cfg.edge_mode & src_edge)
        | (~wake_cfg.edge_mode & src_lvl));
    assign any_start = |src_start;
    // lowest index is highest priority
    assign src_pick = wake_latch & (~wake_latch + 4'h1);
    // first released latched source completes exit
    assign latched_release = |(wake_latch & ~src_lvl);
    assign rst_low = !pins_s[2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_lvl_q <= 4'h0;
        end else begin
            src_lvl_q <= src_lvl;
        end
    end

    // ------------------------------------------------------------------
    // reset hold and keyboard wait counters
    // ------------------------------------------------------------------
    logic rst_zero;
    logic kbd_zero;
    logic kbd_load;

    ipc_count #(.W(5)) u_rst_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(!rst_low),
        .load_val(5'(`IPC_RST_HOLD_CYC - 1)),
        .en(rst_low),
        .zero(rst_zero)
    );

    assign kbd_load = (state == ipc_pkg::IPC_WAKE) && wake_latch[2];

    ipc_count #(.W(11)) u_kbd_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(kbd_load),
        .load_val(11'(`IPC_KBD_WAIT_CYC - 1)),
        .en(state == ipc_pkg::IPC_KWAIT),
        .zero(kbd_zero)
    );

    // ------------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_pwr = power_control_register;
        next_wake_latch = wake_latch;
        next_wake_valid = 1'b0;
        next_wake_src = wake_src;
        case (state)
            ipc_pkg::IPC_RUN: begin
                if (power_control_register.pdown) begin
                    next_state = ipc_pkg::IPC_PDOWN;
                end else if (power_control_register.idle) begin
                    next_state = ipc_pkg::IPC_IDLE;
                end
            end
            ipc_pkg::IPC_IDLE: begin
                if (irq_pending) begin
                    next_pwr.idle = 1'b0;
                    next_state = ipc_pkg::IPC_RUN;
                end
            end
            ipc_pkg::IPC_PDOWN: begin
                if (any_start) begin
                    next_wake_latch = src_start;
                    next_state = ipc_pkg::IPC_WAKE;
                end
            end
            ipc_pkg::IPC_WAKE: begin
                if (wake_latch[2]) begin
                    next_state = ipc_pkg::IPC_KWAIT;
                end else if (latched_release) begin
                    next_pwr.pdown = 1'b0;
                    next_wake_valid = 1'b1;
                    next_wake_src = src_pick;
                    next_state = ipc_pkg::IPC_RUN;
                end
            end
            ipc_pkg::IPC_KWAIT: begin
                if (kbd_zero) begin
                    next_pwr.pdown = 1'b0;
                    next_wake_valid = 1'b1;
                    next_wake_src = src_pick;
                    next_state = ipc_pkg::IPC_RUN;
                end
            end
            ipc_pkg::IPC_RESET: begin
                if (!rst_low) begin
                    next_state = ipc_pkg::IPC_RUN;
                end
            end
            default: begin
                next_state = ipc_pkg::IPC_RUN;
            end
        endcase
        // software write wins over a hardware clear
        if (wr_pwr) begin
            next_pwr = ipc_pkg::ipc_pwr_ctrl_t'(w_data[3:0]);
        end
        // held reset overrides every mode
        if (rst_low && rst_zero) begin
            next_state = ipc_pkg::IPC_RESET;
            next_pwr = ipc_pkg::ipc_pwr_ctrl_t'(`IPC_RST_PWR_CTRL);
            next_wake_latch = 4'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ipc_pkg::IPC_RUN;
            power_control_register <=
                ipc_pkg::ipc_pwr_ctrl_t'(`IPC_RST_PWR_CTRL);
            wake_latch <= 4'h0;
            wake_valid <= 1'b0;
            wake_src <= 4'h0;
        end else begin
            state <= next_state;
            power_control_register <= next_pwr;
            wake_latch <= next_wake_latch;
            wake_valid <= next_wake_valid;
            wake_src <= next_wake_src;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_cfg <= ipc_pkg::ipc_wake_cfg_t'(`IPC_RST_WAKE_CFG);
        end else if (wr_cfg) begin
            wake_cfg <= ipc_pkg::ipc_wake_cfg_t'(w_data[7:0]);
        end
    end

    // ------------------------------------------------------------------
    // clock gating and pin control
    // ------------------------------------------------------------------
    logic in_run;
    logic in_pdown;

    assign in_run = (state == ipc_pkg::IPC_RUN)
        && !power_control_register.idle
        && !power_control_register.pdown;
    assign in_pdown = (state == ipc_pkg::IPC_PDOWN)
        || (state == ipc_pkg::IPC_WAKE) || (state == ipc_pkg::IPC_KWAIT);
    // gated cpu clock keeps all state
    assign cpu_clk_en = in_run;
    assign periph_clk_en = !in_pdown;
    // oscillator restarts on a wake or a low reset pin
    assign osc_en = (state != ipc_pkg::IPC_PDOWN) || rst_low;
    assign port_hold = !in_run && (state != ipc_pkg::IPC_RESET);
    assign ale = in_run ? core_ale : 1'b1;
    assign program_store_strobe = in_run ?
        core_program_store_strobe : 1'b1;
    assign core_reset = (state == ipc_pkg::IPC_RESET);
endmodule

/* File: rtl/ipc_params.svh */
// constants for the idle and power-down controller
// assumes inclusion by bare name from the controller module
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define IPC_OFS_PWR_CTRL 8'h00
`define IPC_OFS_WAKE_CFG 8'h04
`define IPC_OFS_STATUS 8'h08

// ----------------------------------------------------------------------
// power control register fields
// ----------------------------------------------------------------------
`define IPC_BIT_IDLE 0
`define IPC_BIT_PDOWN 1
`define IPC_BIT_GENERAL_FLAG_ZERO 2
`define IPC_BIT_GENERAL_FLAG_ONE 3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IPC_RST_PWR_CTRL 4'h0
`define IPC_RST_WAKE_CFG 8'h00

// ----------------------------------------------------------------------
// timing, in clocks of the oscillator-derived clock
// ----------------------------------------------------------------------
`define IPC_RST_HOLD_OSC 24
`define IPC_KBD_WAIT_CLK 1024
`define IPC_RST_HOLD_CYC (`IPC_RST_HOLD_OSC)
`define IPC_KBD_WAIT_CYC (`IPC_KBD_WAIT_CLK)

`endif

/* File: rtl/ipc_pkg.sv */
// types for the idle and power-down controller
// assumes nothing beyond the params header
package ipc_pkg;

    // ------------------------------------------------------------------
    // controller states, gray along run-idle-pd-wake-kwait
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        IPC_RUN = 3'h0,
        IPC_IDLE = 3'h1,
        IPC_PDOWN = 3'h3,
        IPC_WAKE = 3'h2,
        IPC_KWAIT = 3'h6,
        IPC_RESET = 3'h7
    } ipc_state_t;

    // ------------------------------------------------------------------
    // wake source configuration: bit0 pin zero, bit1 pin one, bit2 kbd,
    // bit3 usb
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] edge_mode;
        logic [3:0] enable;
    } ipc_wake_cfg_t;

    typedef struct packed {
        logic general_flag_one;
        logic general_flag_zero;
        logic pdown;
        logic idle;
    } ipc_pwr_ctrl_t;

endpackage

/* File: rtl/ipc_sync.sv */
// two-flop synchroniser for asynchronous pins
// assumes pins idle high after reset
`timescale 1ns/1ps
module ipc_sync #(
    parameter int W = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '1;
            sync_out <= '1;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

/* File: rtl/ipc_count.sv */
// loadable down counter that stops at zero
// assumes load has priority over counting
`timescale 1ns/1ps
module ipc_count #(
    parameter int W = 11
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic en,
    output logic zero
);
    logic [W-1:0] cnt;

    assign zero = (cnt == '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= '1;
        end else if (load) begin
            cnt <= load_val;
        end else if (en && !zero) begin
            cnt <= cnt - 1'b1;
        end
    end
endmodule

/* File: verif/ipc_core_model.sv */
// core-side model: toggles the bus strobes while the cpu is clocked
// assumes the controller gates the core through cpu_clk_en
`timescale 1ns/1ps
module ipc_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cpu_clk_en,
    output logic core_ale,
    output logic core_program_store_strobe
);
    // strobes freeze with the gated clock, so the core keeps its state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_ale <= 1'b0;
            core_program_store_strobe <= 1'b1;
        end else if (cpu_clk_en) begin
            core_ale <= !core_ale;
            core_program_store_strobe <= core_ale;
        end
    end
endmodule

/* File: verif/ipc_ctrl_sva.sv */
// assertions on the controller ports
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ps
module ipc_ctrl_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic irq_pending,
    input wire logic hw_reset_n,
    input wire logic core_ale,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic osc_en,
    input wire logic port_hold,
    input wire logic ale,
    input wire logic program_store_strobe,
    input wire logic core_reset,
    input wire logic wake_valid,
    input wire logic [3:0] wake_src
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // reset pin low-run counter
    // ------------------------------------------------------------
    logic [5:0] low_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_reset_n) begin
            low_cnt <= 6'h00;
        end else if (low_cnt != 6'h3f) begin
            low_cnt <= low_cnt + 6'h01;
        end
    end

    sequence s_idle;
        !cpu_clk_en && periph_clk_en && !core_reset;
    endsequence
    sequence s_resume;
        ##[1:3] cpu_clk_en;
    endsequence

    chk_idle_strobes: assert property (
        !cpu_clk_en |-> ale && program_store_strobe)
        else $error("strobes not high while cpu stopped");
    chk_idle_ports: assert property (
        s_idle |-> port_hold)
        else $error("ports not held while idle");
    chk_run_pass: assert property (
        cpu_clk_en |-> ale == core_ale)
        else $error("ale not passed while running");
    chk_idle_wake: assert property (
        s_idle and irq_pending |-> s_resume)
        else $error("idle not ended by interrupt");
    chk_pd_osc: assert property (
        $fell(periph_clk_en) |-> !osc_en)
        else $error("oscillator running in power-down");
    chk_pd_keep: assert property (
        !periph_clk_en |-> !cpu_clk_en)
        else $error("cpu clocked in power-down");
    chk_wake_pulse: assert property (
        wake_valid |-> cpu_clk_en ##1 !wake_valid)
        else $error("wake pulse wrong");
    chk_wake_onehot: assert property (
        wake_valid |-> $onehot(wake_src))
        else $error("wake source not one-hot");
    chk_reset_len: assert property (
        $rose(core_reset) |-> low_cnt >= 6'd24)
        else $error("reset taken too early");
    chk_reset_state: assert property (
        core_reset |-> !cpu_clk_en && !port_hold)
        else $error("reset state outputs wrong");
endmodule

bind ipc_ctrl ipc_ctrl_chk u_chk (.aclk, .aresetn, .irq_pending,
    .hw_reset_n, .core_ale, .cpu_clk_en, .periph_clk_en, .osc_en,
    .port_hold, .ale, .program_store_strobe, .core_reset, .wake_valid,
    .wake_src);

/* File: verif/test_idle_powerdown_control.sv */
// self-checking bench for the idle and power-down controller
// assumes ipc_ctrl, its checker and the core model are compiled first
`timescale 1ns/1ps
module test_idle_powerdown_control;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic irq = 1'b0, kbd = 1'b0, usb = 1'b0;
    logic i0_n = 1'b1, i1_n = 1'b1, hrst_n = 1'b1;
    logic c_ale, c_pss, cpu_en, per_en, osc_en, hold, ale, pss, crst, wv;
    logic [3:0] wsrc;
    logic [31:0] d;
    int bad_count = 0, n_checks = 0, n;

    always #4 aclk = ~aclk;

    ipc_core_model u_core (.aclk(aclk), .aresetn(aresetn),
        .cpu_clk_en(cpu_en), .core_ale(c_ale),
        .core_program_store_strobe(c_pss));

    ipc_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq_pending(irq), .kbd_irq(kbd),
        .usb_irq(usb), .external_irq_zero_n(i0_n),
        .external_irq_one_n(i1_n), .hw_reset_n(hrst_n), .core_ale(c_ale),
        .core_program_store_strobe(c_pss), .cpu_clk_en(cpu_en),
        .periph_clk_en(per_en), .osc_en(osc_en), .port_hold(hold),
        .ale(ale), .program_store_strobe(pss), .core_reset(crst),
        .wake_valid(wv), .wake_src(wsrc));

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // axi4-lite master
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int t;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (t = 0; t < 100; t++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
        if (t == 100) bad_count++;
    endtask

    task automatic rd(input logic [7:0] a);
        int t;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (t = 0; t < 100; t++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
        if (t == 100) bad_count++;
    endtask

    task automatic wait_osc;
        for (n = 0; n < 100 && osc_en !== 1'b1; n++) @(posedge aclk);
    endtask

    // power-down, wake by the sources in s, wake_src must read e
    task automatic pd_wake(input logic [7:0] cfg, input logic [3:0] s,
                           input logic [3:0] e);
        int c;
        wr(8'h04, {24'h0, cfg});
        wr(8'h00, 32'h2);
        repeat (4) @(posedge aclk);
        chk("osc_en", 0, osc_en);
        chk("periph", 0, per_en);
        irq <= 1'b1;
        repeat (6) @(posedge aclk);
        irq <= 1'b0;
        chk("osc_en", 0, osc_en);
        {usb, kbd, i1_n, i0_n} <= {s[3:2], ~s[1:0]};
        c = 0;
        wait_osc();
        chk("osc_restart", 1, osc_en);
        chk("cpu_clk_en", 0, cpu_en);
        repeat (4) @(posedge aclk);
        if (s == 4'h3) i1_n <= 1'b1;
        else {usb, kbd, i1_n, i0_n} <= 4'h3;
        for (c = n + 4; c < 2000 && wv !== 1'b1; c++) @(posedge aclk);
        chk("wake_valid", 1, wv);
        chk("wake_src", e, wsrc);
        if (s[2]) chk("kbd_wait", 1, c >= 1024);
        {usb, kbd, i1_n, i0_n} <= 4'h3;
        repeat (4) @(posedge aclk);
        chk("cpu_clk_en", 1, cpu_en);
        $display("power-down wake %h done", s);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00);
        chk("pwr_ctrl", 0, d);
        rd(8'h04);
        chk("wake_cfg", 0, d);
        rd(8'h0c);
        chk("rresp", 2, resp);
        wr(8'h0c, 32'h5);
        chk("bresp", 2, resp);
        wr(8'h00, 32'hc);
        rd(8'h00);
        chk("flags", 32'hc, d);
        $display("register test done");

        wr(8'h00, 32'hd);
        repeat (3) @(posedge aclk);
        chk("cpu_clk_en", 0, cpu_en);
        chk("periph", 1, per_en);
        chk("port_hold", 1, hold);
        chk("strobes", 3, {ale, pss});
        irq <= 1'b1;
        for (n = 0; n < 10 && cpu_en !== 1'b1; n++) @(posedge aclk);
        irq <= 1'b0;
        chk("idle_exit", 1, cpu_en);
        rd(8'h00);
        chk("pwr_ctrl", 32'hc, d);
        $display("idle test done");

        pd_wake(8'h01, 4'h1, 4'h1);
        pd_wake(8'h03, 4'h3, 4'h1);
        pd_wake(8'h04, 4'h4, 4'h4);
        pd_wake(8'h88, 4'h8, 4'h8);

        hrst_n <= 1'b0;
        repeat (10) @(posedge aclk);
        hrst_n <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("short_reset", 0, crst);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h6);
        repeat (4) @(posedge aclk);
        hrst_n <= 1'b0;
        repeat (30) @(posedge aclk);
        chk("core_reset", 1, crst);
        chk("osc_en", 1, osc_en);
        hrst_n <= 1'b1;
        repeat (5) @(posedge aclk);
        chk("core_reset", 0, crst);
        rd(8'h00);
        chk("pwr_ctrl", 0, d);
        $display("reset test done");
        end_sim();
    end

    initial begin
        #100000;
        bad_count++;
        end_sim();
    end
endmodule
